// >>> sfpc_pkg.sv
package sfpc_pkg;
  localparam int unsigned SFPC_NPA = 4;
  localparam int unsigned SFPC_NPB = 8;
  localparam int unsigned SFPC_AW = 3;
  localparam int unsigned SFPC_DW = 8;
  // register indices (byte addresses on the plain port)
  localparam logic [2:0] SFPC_A_FUNC = 3'h0;
  localparam logic [2:0] SFPC_A_DIR = 3'h1;
  localparam logic [2:0] SFPC_A_OUT = 3'h2;
  localparam logic [2:0] SFPC_A_PIN = 3'h3;
  localparam logic [2:0] SFPC_B_FUNC = 3'h4;
  localparam logic [2:0] SFPC_B_DIR = 3'h5;
  localparam logic [2:0] SFPC_B_OUT = 3'h6;
  localparam logic [2:0] SFPC_B_PIN = 3'h7;
  // port c bit 0 lives in the port a registers at this bit
  localparam int unsigned SFPC_C0_BIT = 7;
  localparam logic [7:0] SFPC_RST_FUNC = 8'h00;
  localparam logic [7:0] SFPC_RST_DIR = 8'h00;
  localparam logic [7:0] SFPC_RST_OUT = 8'h00;
  // port b bit positions
  localparam int unsigned SFPC_SC_LO = 0;
  localparam int unsigned SFPC_TC_LO = 3;
  localparam int unsigned SFPC_DIR_BIT = 6;
  localparam int unsigned SFPC_CLK_BIT = 7;
  // simple action control codes per output: 2 bits
  localparam logic [1:0] SFPC_ACT_LOW = 2'h0;
  localparam logic [1:0] SFPC_ACT_ALO = 2'h1;
  localparam logic [1:0] SFPC_ACT_AHI = 2'h2;
  localparam logic [1:0] SFPC_ACT_HIGH = 2'h3;
endpackage

// >>> sfpc_pin_mux.sv
`timescale 1ns/10ps
module sfpc_pin_mux (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [3:0] porta_in,
  output logic [3:0] porta_out,
  output logic [3:0] porta_oe,
  input wire logic [7:0] portb_in,
  output logic [7:0] portb_out,
  output logic [7:0] portb_oe,
  input wire logic portc_bit0_in,
  output logic portc_bit0_out,
  output logic portc_bit0_oe,
  input wire logic [2:0] simple_compare_match,
  input wire logic [5:0] simple_action_control,
  input wire logic [2:0] timer_compare,
  input wire logic protect_mask,
  input wire logic power_drive_protect_n,
  output logic [1:0] first_converter_sel,
  output logic [1:0] second_converter_sel,
  output logic timer_count_direction_in,
  output logic timer_external_clock_in,
  output logic timer_external_clock_sel,
  output logic converter_start_in
);
  logic [7:0] a_func_r, a_dir_r, a_out_r, b_func_r, b_dir_r, b_out_r;
  logic [3:0] pa_s1_r, pa_s2_r;
  logic [7:0] pb_s1_r, pb_s2_r;
  logic pc_s1_r, pc_s2_r, pdp_s1_r, pdp_s2_r;
  logic trip;
  logic [7:0] b_drv_nxt, b_oe_nxt;

  // action control qualifies raw compare; polarity codes per pin
  function automatic logic sfpc_act(input logic [1:0] c, input logic m);
    unique case (c)
      sfpc_pkg::SFPC_ACT_LOW: sfpc_act = 1'b0;
      sfpc_pkg::SFPC_ACT_ALO: sfpc_act = ~m;
      sfpc_pkg::SFPC_ACT_AHI: sfpc_act = m;
      sfpc_pkg::SFPC_ACT_HIGH: sfpc_act = 1'b1;
    endcase
  endfunction

  // register writes; reset gives gp inputs everywhere
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_func_r <= sfpc_pkg::SFPC_RST_FUNC;
      a_dir_r <= sfpc_pkg::SFPC_RST_DIR;
      a_out_r <= sfpc_pkg::SFPC_RST_OUT;
      b_func_r <= sfpc_pkg::SFPC_RST_FUNC;
      b_dir_r <= sfpc_pkg::SFPC_RST_DIR;
      b_out_r <= sfpc_pkg::SFPC_RST_OUT;
    end else if (wr) begin
      unique case (addr)
        sfpc_pkg::SFPC_A_FUNC: a_func_r <= wdata;
        sfpc_pkg::SFPC_A_DIR: a_dir_r <= wdata;
        sfpc_pkg::SFPC_A_OUT: a_out_r <= wdata;
        sfpc_pkg::SFPC_B_FUNC: b_func_r <= wdata;
        sfpc_pkg::SFPC_B_DIR: b_dir_r <= wdata;
        sfpc_pkg::SFPC_B_OUT: b_out_r <= wdata;
        default: ;
      endcase
    end
  end

  // pins come from the board; two flops before any logic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_s1_r <= 4'h0;
      pa_s2_r <= 4'h0;
      pb_s1_r <= 8'h00;
      pb_s2_r <= 8'h00;
      pc_s1_r <= 1'b0;
      pc_s2_r <= 1'b0;
      pdp_s1_r <= 1'b1;
      pdp_s2_r <= 1'b1;
    end else begin
      pa_s1_r <= porta_in;
      pa_s2_r <= pa_s1_r;
      pb_s1_r <= portb_in;
      pb_s2_r <= pb_s1_r;
      pc_s1_r <= portc_bit0_in;
      pc_s2_r <= pc_s1_r;
      pdp_s1_r <= power_drive_protect_n;
      pdp_s2_r <= pdp_s1_r;
    end
  end

  // protect trip is a level: unless masked, compare-role pins stay floated while input is low
  assign trip = ~protect_mask & ~pdp_s2_r;

  // port b drive selection
  always_comb begin
    b_drv_nxt = b_out_r;
    b_oe_nxt = b_dir_r;
    for (int i = 0; i < 3; i++) begin
      if (b_func_r[sfpc_pkg::SFPC_SC_LO + i]) begin
        b_drv_nxt[sfpc_pkg::SFPC_SC_LO + i] =
          sfpc_act(simple_action_control[2*i +: 2], simple_compare_match[i]);
        b_oe_nxt[sfpc_pkg::SFPC_SC_LO + i] = ~trip;
      end
      if (b_func_r[sfpc_pkg::SFPC_TC_LO + i]) begin
        b_drv_nxt[sfpc_pkg::SFPC_TC_LO + i] = timer_compare[i];
        b_oe_nxt[sfpc_pkg::SFPC_TC_LO + i] = ~trip;
      end
    end
    // input-role pins never drive
    if (b_func_r[sfpc_pkg::SFPC_DIR_BIT]) begin
      b_oe_nxt[sfpc_pkg::SFPC_DIR_BIT] = 1'b0;
    end
    if (b_func_r[sfpc_pkg::SFPC_CLK_BIT]) begin
      b_oe_nxt[sfpc_pkg::SFPC_CLK_BIT] = 1'b0;
    end
  end

  // registered pin drivers; analog role never drives the pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      porta_out <= 4'h0;
      porta_oe <= 4'h0;
      portb_out <= 8'h00;
      portb_oe <= 8'h00;
      portc_bit0_out <= 1'b0;
      portc_bit0_oe <= 1'b0;
    end else begin
      porta_out <= a_out_r[3:0];
      porta_oe <= a_dir_r[3:0] & ~a_func_r[3:0];
      portb_out <= b_drv_nxt;
      portb_oe <= b_oe_nxt;
      portc_bit0_out <= a_out_r[sfpc_pkg::SFPC_C0_BIT];
      portc_bit0_oe <= a_dir_r[sfpc_pkg::SFPC_C0_BIT] & ~a_func_r[sfpc_pkg::SFPC_C0_BIT];
    end
  end

  // peripheral-side signals
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_converter_sel <= 2'h0;
      second_converter_sel <= 2'h0;
      timer_count_direction_in <= 1'b0;
      timer_external_clock_in <= 1'b0;
      timer_external_clock_sel <= 1'b0;
      converter_start_in <= 1'b0;
    end else begin
      first_converter_sel <= a_func_r[1:0];
      second_converter_sel <= a_func_r[3:2];
      // up count (0) when pin not in role
      timer_count_direction_in <= b_func_r[sfpc_pkg::SFPC_DIR_BIT]
        & pb_s2_r[sfpc_pkg::SFPC_DIR_BIT];
      timer_external_clock_sel <= b_func_r[sfpc_pkg::SFPC_CLK_BIT];
      // sampled clock: fine for slow external clocks only
      timer_external_clock_in <= b_func_r[sfpc_pkg::SFPC_CLK_BIT]
        & pb_s2_r[sfpc_pkg::SFPC_CLK_BIT];
      converter_start_in <= a_func_r[sfpc_pkg::SFPC_C0_BIT] & pc_s2_r;
    end
  end

  // read port: data stands the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        sfpc_pkg::SFPC_A_FUNC: rdata <= a_func_r;
        sfpc_pkg::SFPC_A_DIR: rdata <= a_dir_r;
        sfpc_pkg::SFPC_A_OUT: rdata <= a_out_r;
        sfpc_pkg::SFPC_A_PIN: rdata <= {pc_s2_r, 3'h0, pa_s2_r};
        sfpc_pkg::SFPC_B_FUNC: rdata <= b_func_r;
        sfpc_pkg::SFPC_B_DIR: rdata <= b_dir_r;
        sfpc_pkg::SFPC_B_OUT: rdata <= b_out_r;
        sfpc_pkg::SFPC_B_PIN: rdata <= pb_s2_r;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // checks: reset state, seen at the first edge after release
  reset_float_a: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> (porta_oe == 4'h0) && (portb_oe == 8'h00) && !portc_bit0_oe)
    else $error("pins not inputs after reset");

  reset_func_a: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> (b_func_r == 8'h00) && (a_func_r == 8'h00))
    else $error("functions not gp after reset");

  reset_read_a: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> rdata == 8'h00)
    else $error("read data not clear after reset");

  // analog role: pin left alone, converter told which inputs it owns
  analog_nodrive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    a_func_r[0] |=> !porta_oe[0])
    else $error("analog pin driven");

  conv_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> first_converter_sel == $past(a_func_r[1:0])
      && second_converter_sel == $past(a_func_r[3:2]))
    else $error("converter select not from function bits");

  // simple compare drive, two action codes on two pins
  sc_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    b_func_r[0] && simple_action_control[1:0] == sfpc_pkg::SFPC_ACT_HIGH && !trip
    |=> portb_out[0] && portb_oe[0])
    else $error("compare pin not driven per action");

  sc_invert_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    b_func_r[1] && simple_action_control[3:2] == sfpc_pkg::SFPC_ACT_ALO && !trip
    |=> portb_out[1] == !$past(simple_compare_match[1]) && portb_oe[1])
    else $error("active low action not applied");

  // protect: float on unmasked low, drive again once masked
  sc_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trip && b_func_r[2] |=> !portb_oe[2])
    else $error("compare pin not floated");

  mask_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    protect_mask && b_func_r[0] |=> portb_oe[0])
    else $error("masked protect floated a pin");

  // two sync edges then the pin flop: pin sampled low, floated three edges on
  tc_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !protect_mask && !power_drive_protect_n ##2 !protect_mask && b_func_r[3]
    |=> !portb_oe[3])
    else $error("timer pin not floated");

  tc_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    b_func_r[3] && !trip |=> portb_oe[3] && portb_out[3] == $past(timer_compare[0]))
    else $error("timer pin not driven from compare");

  // timer inputs: never driven, level passed through the synchroniser
  dir_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    b_func_r[6] [*4] |-> timer_count_direction_in == $past(portb_in[6], 3))
    else $error("direction not from pin");

  dir_nodrive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    b_func_r[6] |=> !portb_oe[6])
    else $error("direction pin driven");

  clk_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !b_func_r[7] |=> !timer_external_clock_sel && !timer_external_clock_in)
    else $error("clock routed when gp");

  clk_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    b_func_r[7] |=> timer_external_clock_sel && !portb_oe[7])
    else $error("clock role not selected");

  // conversion start on port c bit 0
  soc_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !a_func_r[7] |=> !converter_start_in)
    else $error("start routed when gp");

  soc_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    a_func_r[7] [*4] |-> converter_start_in == $past(portc_bit0_in, 3))
    else $error("start not from pin");

  // general-purpose path: direction, level and read port
  gp_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr && addr == sfpc_pkg::SFPC_B_DIR && !b_func_r[4] |=> ##1 portb_oe[4] == $past(wdata[4], 2))
    else $error("gp direction not applied");

  gpa_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !a_func_r[0] && a_dir_r[0] |=> porta_oe[0] && porta_out[0] == $past(a_out_r[0]))
    else $error("port a gp level not driven");

  gpb_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !b_func_r[1] && b_dir_r[1] |=> portb_oe[1] && portb_out[1] == $past(b_out_r[1]))
    else $error("port b gp level not driven");

  gpc_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !a_func_r[7] && a_dir_r[7] |=> portc_bit0_oe && portc_bit0_out == $past(a_out_r[7]))
    else $error("port c gp level not driven");

  rd_func_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd && addr == sfpc_pkg::SFPC_B_FUNC |=> rdata == $past(b_func_r))
    else $error("function register read wrong");

  // read data must not linger, software may poll without a strobe
  rd_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rd |=> rdata == 8'h00)
    else $error("read data not cleared");

  // main scenarios
  cov_trip_c: cover property (@(posedge sys_clk) disable iff (!rst_n) trip && b_func_r[0]);
  cov_read_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    rd && addr == sfpc_pkg::SFPC_B_PIN);
  cov_soc_c: cover property (@(posedge sys_clk) disable iff (!rst_n) converter_start_in);
  cov_mask_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    protect_mask && !pdp_s2_r && b_func_r[0]);
  cov_down_c: cover property (@(posedge sys_clk) disable iff (!rst_n) timer_count_direction_in);
endmodule

// >>> sfpc_board.sv
`timescale 1ns/10ps
// board circuitry on the pin side: a pin the block drives carries the block's level
module sfpc_board (
  input wire logic [3:0] porta_out,
  input wire logic [3:0] porta_oe,
  input wire logic [7:0] portb_out,
  input wire logic [7:0] portb_oe,
  input wire logic portc_bit0_out,
  input wire logic portc_bit0_oe,
  input wire logic [3:0] board_a,
  input wire logic [7:0] board_b,
  input wire logic board_c,
  output logic [3:0] porta_in,
  output logic [7:0] portb_in,
  output logic portc_bit0_in
);
  // the board's own level shows only where the block has let go of the pin
  assign porta_in = (porta_oe & porta_out) | (~porta_oe & board_a);
  assign portb_in = (portb_oe & portb_out) | (~portb_oe & board_b);
  assign portc_bit0_in = portc_bit0_oe ? portc_bit0_out : board_c;
endmodule

// >>> sfpc_pin_mux_bench.sv
`timescale 1ns/10ps
module sfpc_pin_mux_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, pb_in, pb_out, pb_oe, bd_b = 8'h00;
  logic [3:0] pa_in, pa_out, pa_oe, bd_a = 4'h0;
  logic c_in, c_out, c_oe, bd_c = 1'b0;
  logic [2:0] match = 3'h0;
  logic [2:0] tcmp = 3'h0;
  logic [5:0] sac = 6'h00;
  logic mask = 1'b0;
  logic pdp_n = 1'b1;
  logic [1:0] fsel, ssel;
  logic tdir, tclk, tclk_sel, soc;
  int errors = 0;
  int comparisons = 0;
  always #10 sys_clk = ~sys_clk;
  sfpc_pin_mux sfpc_pin_mux_inst (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .porta_in(pa_in), .porta_out(pa_out), .porta_oe(pa_oe),
    .portb_in(pb_in), .portb_out(pb_out), .portb_oe(pb_oe), .portc_bit0_in(c_in),
    .portc_bit0_out(c_out), .portc_bit0_oe(c_oe), .simple_compare_match(match),
    .simple_action_control(sac), .timer_compare(tcmp), .protect_mask(mask),
    .power_drive_protect_n(pdp_n), .first_converter_sel(fsel), .second_converter_sel(ssel),
    .timer_count_direction_in(tdir), .timer_external_clock_in(tclk),
    .timer_external_clock_sel(tclk_sel), .converter_start_in(soc));
  sfpc_board sfpc_board_inst (.porta_out(pa_out), .porta_oe(pa_oe), .portb_out(pb_out),
    .portb_oe(pb_oe), .portc_bit0_out(c_out), .portc_bit0_oe(c_oe), .board_a(bd_a),
    .board_b(bd_b), .board_c(bd_c), .porta_in(pa_in), .portb_in(pb_in), .portc_bit0_in(c_in));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one-cycle strobe; the edge after it releases the strobe
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // sync flops plus register stage take three edges at most
  task automatic settle();
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic results();
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_reset();
    logic [7:0] d;
    chk("porta_oe", 8'h00, 8'(pa_oe));
    chk("portb_oe", 8'h00, pb_oe);
    chk("portc_oe", 8'h00, 8'(c_oe));
    rd_reg(sfpc_pkg::SFPC_B_FUNC, d);
    chk("b_func", 8'h00, d);
  endtask
  task automatic t_gpio();
    logic [7:0] d;
    bd_a <= 4'h2;
    wr_reg(sfpc_pkg::SFPC_A_DIR, 8'h05);
    wr_reg(sfpc_pkg::SFPC_A_OUT, 8'h04);
    wr_reg(sfpc_pkg::SFPC_B_DIR, 8'h10);
    settle();
    chk("porta_oe", 8'h05, 8'(pa_oe));
    chk("portb_oe", 8'h10, pb_oe);
    rd_reg(sfpc_pkg::SFPC_A_PIN, d);
    chk("a_pin", 8'h06, 8'(d[3:0]));
  endtask
  task automatic t_analog();
    wr_reg(sfpc_pkg::SFPC_A_FUNC, 8'h06);
    settle();
    chk("first_sel", 8'h02, 8'(fsel));
    chk("second_sel", 8'h01, 8'(ssel));
  endtask
  // every action code on all three simple outputs, timer outputs beside them
  task automatic t_compare();
    logic [2:0] e [4];
    e = '{3'h0, 3'h2, 3'h5, 3'h7};
    match <= 3'h5;
    tcmp <= 3'h3;
    wr_reg(sfpc_pkg::SFPC_B_FUNC, 8'h3f);
    for (int c = 0; c < 4; c++) begin
      sac <= {3{2'(c)}};
      settle();
      chk("simple_out", 8'(e[c]), 8'(pb_out[2:0]));
      chk("timer_out", 8'h03, 8'(pb_out[5:3]));
      chk("cmp_oe", 8'h3f, 8'(pb_oe[5:0]));
    end
  endtask
  task automatic t_protect();
    pdp_n <= 1'b0;
    settle();
    chk("simple_oe", 8'h00, 8'(pb_oe[2:0]));
    chk("timer_oe", 8'h00, 8'(pb_oe[5:3]));
    mask <= 1'b1;
    settle();
    chk("masked_oe", 8'h3f, 8'(pb_oe[5:0]));
    mask <= 1'b0;
    pdp_n <= 1'b1;
    settle();
    chk("restored_oe", 8'h3f, 8'(pb_oe[5:0]));
  endtask
  task automatic t_timer();
    wr_reg(sfpc_pkg::SFPC_B_FUNC, 8'hc0);
    bd_b <= 8'hc0;
    settle();
    chk("dir_down", 8'h01, 8'(tdir));
    chk("clk_sel", 8'h01, 8'(tclk_sel));
    chk("clk_in", 8'h01, 8'(tclk));
    bd_b <= 8'h00;
    settle();
    chk("dir_up", 8'h00, 8'(tdir));
    chk("clk_low", 8'h00, 8'(tclk));
  endtask
  task automatic t_start();
    wr_reg(sfpc_pkg::SFPC_A_FUNC, 8'h80);
    bd_c <= 1'b1;
    settle();
    chk("start_hi", 8'h01, 8'(soc));
    bd_c <= 1'b0;
    settle();
    chk("start_lo", 8'h00, 8'(soc));
  endtask
  // gp outputs on ports b and c; port b seen back through the pins and the read port
  task automatic t_readback();
    logic [7:0] d;
    wr_reg(sfpc_pkg::SFPC_A_FUNC, 8'h00);
    wr_reg(sfpc_pkg::SFPC_A_DIR, 8'h80);
    wr_reg(sfpc_pkg::SFPC_A_OUT, 8'h80);
    wr_reg(sfpc_pkg::SFPC_B_DIR, 8'h30);
    wr_reg(sfpc_pkg::SFPC_B_OUT, 8'h30);
    settle();
    chk("portc_oe", 8'h01, 8'(c_oe));
    chk("portc_out", 8'h01, 8'(c_out));
    rd_reg(sfpc_pkg::SFPC_B_PIN, d);
    chk("b_pin", 8'h30, d);
    @(posedge sys_clk);
    #1 chk("rdata_idle", 8'h00, rdata);
  endtask
  // a hang is cut short here and counted
  initial begin
    #1000000;
    errors++;
    results();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_gpio();
    t_analog();
    t_compare();
    t_protect();
    t_timer();
    t_start();
    t_readback();
    results();
  end
endmodule
